// [common/esr_consts.svh]
// Constants for the error-status reporter: summary and detail bit positions, reset values, timing.
// Assumes a 200 MHz reference clock.
`ifndef ESR_CONSTS_SVH
`define ESR_CONSTS_SVH

`define ESR_BIT_SUPPLY        6
`define ESR_BIT_ELECTROMETER  5
`define ESR_BIT_FILTER        4
`define ESR_BIT_MULTIPLIER    3
`define ESR_BIT_FILAMENT      1
`define ESR_BIT_COMMS         0
`define ESR_SUMMARY_RESET     8'h00
`define ESR_DETAIL_RESET      8'h00
`define ESR_COMMS_BAD_CMD     0
`define ESR_FIL_SHUTDOWN      6
`define ESR_CLK_MHZ           200
`define ESR_FLASH_MS          250
`define ESR_FLASH_CYCLES      (`ESR_FLASH_MS * 1000 * `ESR_CLK_MHZ)

`endif

// [common/esr_pkg.sv]
// Types for the error-status reporter.
// Assumes esr_consts.svh holds the numeric constants.
package esr_pkg;
	typedef enum logic [2:0] {
		ESR_Q_SUMMARY      = 3'b000,
		ESR_Q_SUPPLY       = 3'b001,
		ESR_Q_ELECTROMETER = 3'b010,
		ESR_Q_FILTER       = 3'b011,
		ESR_Q_MULTIPLIER   = 3'b100,
		ESR_Q_FILAMENT     = 3'b101,
		ESR_Q_COMMS        = 3'b110
	} esr_query_t;

	typedef struct packed {
		logic       valid;
		esr_query_t code;
	} esr_query_req_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} esr_reply_t;

	// One fault strobe bus per check: bit set means that test failed this cycle
	typedef struct packed {
		logic [7:0] supply;
		logic [7:0] electrometer;
		logic [7:0] filter;
		logic [7:0] multiplier;
		logic [7:0] filament;
		logic [7:0] comms;
	} esr_faults_t;

	typedef enum logic [1:0] {
		ESR_LED_IDLE  = 2'b00,
		ESR_LED_ON    = 2'b01,
		ESR_LED_OFF   = 2'b10
	} esr_flash_t;
endpackage

// [design/esr_error_status_reporter.sv]
// Error-status aggregation: six detail bytes, a summary byte, panel indicators
// and query/answer handling for the command link.
// Assumes the command parser delivers decoded queries and end-of-command strobes
// on ref_clk_in, and that the checks deliver fault strobes on the same clock.
//
// Function
// R1 - Summary byte bit 6 supply, 5 electrometer, 4 mass filter, 3 multiplier, 1 filament, 0 comms; 7 and 2 zero.
// R2 - An all-zero summary means no detected error; any set bit marks a problem.
// R3 - Each check keeps its own detail byte, returned when the host queries it.
// R4 - The error indicator turns on steadily at once while any summary bit 1 to 7 is set.
// R5 - A newly set comms bit flashes the error indicator exactly twice, never steady.
// R6 - Filament shutdown or failed emission lights burnt and leak together with error.
// R7 - Hardware commands run checks and end by returning the current summary byte; here an end coinciding with a retest answer returns no summary.
// R8 - After power-on reset the supply, electrometer and filter checks run automatically.
// R9 - While the filament is on, overpressure shuts it down and flags the filament error.
// R10 - Checks keep running and update detail and summary bits whenever one fails.
// R11 - With any summary bit set the host queries each matching detail byte.
// R12 - The host polls the summary byte and checks every end-of-command summary.
// R13 - Some detail queries rerun a test before answering, others clear on read.
// R14 - An unrecognized command string sets bit 0 of the comms detail byte.
// R15 - Each used summary bit is one exactly when its detail byte is nonzero.
`include "esr_consts.svh"

module esr_error_status_reporter #(
	parameter int unsigned FLASH_CYCLES = `ESR_FLASH_CYCLES
) (
	input  wire logic                   ref_clk_in,
	input  wire logic                   reset_n_in,
	input  wire esr_pkg::esr_query_req_t query_in,
	input  wire logic                   cmd_done_in,
	input  wire logic                   bad_cmd_in,
	input  wire esr_pkg::esr_faults_t   faults_in,
	input  wire logic                   filament_on_in,
	input  wire logic                   overpressure_in,
	input  wire logic                   emission_fail_in,
	input  wire logic                   retest_done_in,
	input  wire esr_pkg::esr_faults_t   retest_in,
	output esr_pkg::esr_reply_t         reply_out,
	output logic [7:0]                  summary_out,
	output logic                        selftest_req_out,
	output logic [2:0]                  retest_req_out,
	output logic                        filament_off_out,
	output logic                        error_led_out,
	output logic                        burnt_led_out,
	output logic                        leak_led_out
);
	import esr_pkg::*;

	localparam int FW = $clog2(FLASH_CYCLES + 1);

	logic [7:0]  supply_detail_byte_q;
	logic [7:0]  electrometer_detail_byte_q;
	logic [7:0]  filter_detail_byte_q;
	logic [7:0]  multiplier_detail_byte_q;
	logic [7:0]  filament_detail_byte_q;
	logic [7:0]  comms_detail_byte_q;
	logic [7:0]  summary_d;
	logic        selftest_done_q;
	logic        retest_wait_q;
	esr_query_t  retest_code_q;
	logic        prot_trip;
	logic        comms_prev_q;
	esr_flash_t  flash_q;
	logic [1:0]  flash_left_q;
	logic [FW-1:0] flash_cnt_q;
	logic        query_take;
	logic        rd_comms;
	logic        rd_multiplier;
	logic        rd_filament;

	// Background protection is only armed while the filament is energized
	assign prot_trip = filament_on_in && overpressure_in; // R9

	// A dropped query must not clear a byte the host never received
	assign query_take = query_in.valid && !retest_wait_q && !cmd_done_in;

	// Supply, electrometer and filter answer after a fresh test; the rest clear on read
	assign rd_comms      = query_take && query_in.code == ESR_Q_COMMS; // R13
	assign rd_multiplier = query_take && query_in.code == ESR_Q_MULTIPLIER; // R13
	assign rd_filament   = query_take && query_in.code == ESR_Q_FILAMENT; // R13

	always_comb begin
		summary_d = `ESR_SUMMARY_RESET;
		summary_d[`ESR_BIT_SUPPLY]       = |supply_detail_byte_q; // R15
		summary_d[`ESR_BIT_ELECTROMETER] = |electrometer_detail_byte_q; // R15
		summary_d[`ESR_BIT_FILTER]       = |filter_detail_byte_q; // R15
		summary_d[`ESR_BIT_MULTIPLIER]   = |multiplier_detail_byte_q; // R15
		summary_d[`ESR_BIT_FILAMENT]     = |filament_detail_byte_q; // R15
		summary_d[`ESR_BIT_COMMS]        = |comms_detail_byte_q; // R1 R2
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			summary_out <= `ESR_SUMMARY_RESET;
		end else begin
			summary_out <= summary_d; // R1 R2 R10
		end
	end

	// Power-on self test: one request pulse, results arrive on the faults bus
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			selftest_done_q  <= 1'b0;
			selftest_req_out <= 1'b0;
		end else begin
			selftest_req_out <= !selftest_done_q; // R8
			selftest_done_q  <= 1'b1;
		end
	end

	// Hardware-retested bytes are replaced by the fresh result; sets from the
	// continuous faults bus are OR-ed in so a same-cycle failure is kept.
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			supply_detail_byte_q       <= `ESR_DETAIL_RESET;
			electrometer_detail_byte_q <= `ESR_DETAIL_RESET;
			filter_detail_byte_q       <= `ESR_DETAIL_RESET;
		end else begin
			supply_detail_byte_q       <= supply_detail_byte_q | faults_in.supply; // R10
			electrometer_detail_byte_q <= electrometer_detail_byte_q | faults_in.electrometer;
			filter_detail_byte_q       <= filter_detail_byte_q | faults_in.filter;
			if (retest_done_in && retest_wait_q) begin
				unique case (retest_code_q)
					ESR_Q_SUPPLY: supply_detail_byte_q <=
						retest_in.supply | faults_in.supply; // R13
					ESR_Q_ELECTROMETER: electrometer_detail_byte_q <=
						retest_in.electrometer | faults_in.electrometer; // R13
					ESR_Q_FILTER: filter_detail_byte_q <=
						retest_in.filter | faults_in.filter; // R13
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			multiplier_detail_byte_q <= `ESR_DETAIL_RESET;
			filament_detail_byte_q   <= `ESR_DETAIL_RESET;
			comms_detail_byte_q      <= `ESR_DETAIL_RESET;
		end else begin
			multiplier_detail_byte_q <= (rd_multiplier ? 8'h00 : multiplier_detail_byte_q)
				| faults_in.multiplier; // R10 R13
			filament_detail_byte_q <= (rd_filament ? 8'h00 : filament_detail_byte_q)
				| faults_in.filament
				| ({7'h00, prot_trip} << `ESR_FIL_SHUTDOWN); // R9 R13
			comms_detail_byte_q <= (rd_comms ? 8'h00 : comms_detail_byte_q)
				| faults_in.comms
				| ({7'h00, bad_cmd_in} << `ESR_COMMS_BAD_CMD); // R14 R13
		end
	end

	// Filament shutdown holds until the filament supply reports itself off
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			filament_off_out <= 1'b0;
		end else if (prot_trip) begin
			filament_off_out <= 1'b1; // R9
		end else if (!filament_on_in) begin
			filament_off_out <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			burnt_led_out <= 1'b0;
			leak_led_out  <= 1'b0;
		end else begin
			burnt_led_out <= prot_trip || emission_fail_in || filament_off_out; // R6
			leak_led_out  <= prot_trip || emission_fail_in || filament_off_out; // R6
		end
	end

	// Query handling; supply, electrometer and filter answer after retest
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			reply_out      <= '0;
			retest_wait_q  <= 1'b0;
			retest_code_q  <= ESR_Q_SUMMARY;
			retest_req_out <= 3'h0;
		end else begin
			reply_out      <= '0;
			retest_req_out <= 3'h0;
			if (retest_wait_q && retest_done_in) begin
				retest_wait_q   <= 1'b0;
				reply_out.valid <= 1'b1;
				unique case (retest_code_q)
					ESR_Q_SUPPLY:       reply_out.data <= retest_in.supply; // R13
					ESR_Q_ELECTROMETER: reply_out.data <= retest_in.electrometer;
					ESR_Q_FILTER:       reply_out.data <= retest_in.filter;
					default:            reply_out.data <= 8'h00;
				endcase
			end else if (cmd_done_in) begin
				reply_out.valid <= 1'b1;
				reply_out.data  <= summary_d; // R7
			end else if (query_in.valid && !retest_wait_q) begin
				unique case (query_in.code)
					ESR_Q_SUPPLY, ESR_Q_ELECTROMETER, ESR_Q_FILTER: begin
						retest_wait_q  <= 1'b1;
						retest_code_q  <= query_in.code;
						retest_req_out <= query_in.code[2:0]; // R13
					end
					default: begin
						reply_out.valid <= 1'b1;
						unique case (query_in.code)
							ESR_Q_MULTIPLIER: reply_out.data <= multiplier_detail_byte_q; // R3
							ESR_Q_FILAMENT:   reply_out.data <= filament_detail_byte_q; // R3
							ESR_Q_COMMS:      reply_out.data <= comms_detail_byte_q; // R3
							default:          reply_out.data <= summary_d; // R3
						endcase
					end
				endcase
			end
		end
	end

	// Comms errors flash the indicator twice; any other bit holds it steady
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			comms_prev_q <= 1'b0;
			flash_q      <= ESR_LED_IDLE;
			flash_left_q <= 2'h0;
			flash_cnt_q  <= '0;
		end else begin
			comms_prev_q <= summary_d[`ESR_BIT_COMMS];
			unique case (flash_q)
				ESR_LED_IDLE: if (summary_d[`ESR_BIT_COMMS] && !comms_prev_q) begin
					flash_q      <= ESR_LED_ON; // R5
					flash_left_q <= 2'h2;
					flash_cnt_q  <= FW'(FLASH_CYCLES - 1);
				end
				ESR_LED_ON: if (flash_cnt_q == '0) begin
					flash_q      <= ESR_LED_OFF;
					flash_left_q <= flash_left_q - 2'h1;
					flash_cnt_q  <= FW'(FLASH_CYCLES - 1);
				end else begin
					flash_cnt_q <= flash_cnt_q - 1'b1;
				end
				ESR_LED_OFF: if (flash_cnt_q == '0) begin
					flash_q     <= (flash_left_q == 2'h0) ? ESR_LED_IDLE : ESR_LED_ON; // R5
					flash_cnt_q <= FW'(FLASH_CYCLES - 1);
				end else begin
					flash_cnt_q <= flash_cnt_q - 1'b1;
				end
				default: flash_q <= ESR_LED_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			error_led_out <= 1'b0;
		end else begin
			error_led_out <= (|summary_d[7:1]) || prot_trip || emission_fail_in
				|| filament_off_out || (flash_q == ESR_LED_ON); // R4 R5 R6
		end
	end
endmodule

// [testbench/esr_props.sv]
// Checker for the error-status reporter: port relations over time.
// Assumes one clock domain; bound onto the reporter at the foot.
module esr_props #(
	parameter int unsigned FLASH_CYCLES = 4
) (
	input wire logic                 ref_clk_in,
	input wire logic                 reset_n_in,
	input wire logic                 cmd_done_in,
	input wire logic                 bad_cmd_in,
	input wire esr_pkg::esr_faults_t faults_in,
	input wire logic                 filament_on_in,
	input wire logic                 overpressure_in,
	input wire logic                 emission_fail_in,
	input wire esr_pkg::esr_reply_t  reply_out,
	input wire logic                 selftest_req_out,
	input wire logic [7:0]           summary_out,
	input wire logic [2:0]           retest_req_out,
	input wire logic                 filament_off_out,
	input wire logic                 error_led_out,
	input wire logic                 burnt_led_out,
	input wire logic                 leak_led_out
);
	timeunit 1ns;
	timeprecision 100ps;
	import esr_pkg::*;
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!reset_n_in);
	property p_rsv; !summary_out[7] && !summary_out[2]; endproperty
	a_rsv: assert property (p_rsv) else $error("unused bit set");
	property p_led; |summary_out[7:1] |-> error_led_out; endproperty
	a_led: assert property (p_led) else $error("error led off");
	property p_lamp;
		burnt_led_out || leak_led_out |-> burnt_led_out && leak_led_out && error_led_out;
	endproperty
	a_lamp: assert property (p_lamp) else $error("lamps disagree");
	property p_done; cmd_done_in |=> reply_out.valid && reply_out.data == summary_out; endproperty
	a_done: assert property (p_done) else $error("no end summary");
	property p_retest;
		retest_req_out != 3'h0 |-> retest_req_out <= 3'h3 ##1 retest_req_out == 3'h0;
	endproperty
	a_retest: assert property (p_retest) else $error("bad retest");
	property p_bad; bad_cmd_in |-> ##2 summary_out[0]; endproperty
	a_bad: assert property (p_bad) else $error("comms bit missing");
	property p_sum; faults_in.multiplier != 8'h00 |-> ##2 summary_out[3]; endproperty
	a_sum: assert property (p_sum) else $error("multiplier bit missing");
	property p_fil; filament_on_in && overpressure_in |-> ##[1:2] filament_off_out; endproperty
	a_fil: assert property (p_fil) else $error("no shutdown");
	property p_emis; emission_fail_in |=> burnt_led_out && leak_led_out && error_led_out; endproperty
	a_emis: assert property (p_emis) else $error("no emission lamps");
	property p_self; selftest_req_out |=> !selftest_req_out; endproperty
	a_self: assert property (p_self) else $error("self test request too long");
endmodule

bind esr_error_status_reporter esr_props #(.FLASH_CYCLES(FLASH_CYCLES)) esr_props_inst (
	.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .cmd_done_in(cmd_done_in),
	.bad_cmd_in(bad_cmd_in), .faults_in(faults_in), .filament_on_in(filament_on_in),
	.overpressure_in(overpressure_in), .emission_fail_in(emission_fail_in),
	.selftest_req_out(selftest_req_out), .reply_out(reply_out), .summary_out(summary_out),
	.retest_req_out(retest_req_out), .filament_off_out(filament_off_out),
	.error_led_out(error_led_out), .burnt_led_out(burnt_led_out), .leak_led_out(leak_led_out)
);

// [testbench/esr_host_model.sv]
// Host computer model: sends queries and collects one-byte answers.
// Assumes answers come as one-cycle valid pulses on the reporter clock.
module esr_host_model (
	input  wire logic                ref_clk_in,
	input  wire esr_pkg::esr_reply_t reply_in,
	output esr_pkg::esr_query_req_t  query_out
);
	timeunit 1ns;
	timeprecision 100ps;
	import esr_pkg::*;
	initial query_out = '0;
	// Bounded so a silent device cannot hang the host; looks before it waits,
	// since an answer stands for one cycle only
	task automatic wait_reply(output logic [7:0] d, output bit ok);
		ok = 1'b0;
		d = 8'h00;
		for (int i = 0; i < 60 && !ok; i++) begin
			ok = (reply_in.valid === 1'b1);
			d = reply_in.data;
			if (!ok) begin
				@(posedge ref_clk_in);
				#1;
			end
		end
	endtask
	task automatic ask(input esr_query_t c, output logic [7:0] d, output bit ok);
		@(posedge ref_clk_in);
		#1;
		query_out = '{valid: 1'b1, code: c};
		@(posedge ref_clk_in);
		#1;
		query_out.valid = 1'b0;
		wait_reply(d, ok);
	endtask
endmodule

// [testbench/esr_error_status_reporter_tb_top.sv]
// Testbench for the error-status reporter: check faults, host queries, indicators.
// Assumes a flash period shortened to a few clocks.
module esr_error_status_reporter_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import esr_pkg::*;
	logic           ref_clk_in = 1'b0, reset_n_in = 1'b0, cmd_done_in = 1'b0, bad_cmd_in = 1'b0;
	logic           filament_on_in = 1'b0, overpressure_in = 1'b0, retest_done_in = 1'b0;
	esr_faults_t    faults_in = '0;
	esr_faults_t    retest_in = '0;
	logic           emission_fail_in = 1'b0;
	esr_query_req_t query_in;
	esr_reply_t     reply_out;
	logic [7:0]     summary_out;
	logic [2:0]     retest_req_out;
	logic           selftest_req_out, filament_off_out, error_led_out, burnt_led_out, leak_led_out;
	int             miscompares = 0, cmp_count = 0;
	always #2.5 ref_clk_in = ~ref_clk_in;
	esr_error_status_reporter #(.FLASH_CYCLES(4)) esr_error_status_reporter_inst (
		.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .query_in(query_in),
		.cmd_done_in(cmd_done_in), .bad_cmd_in(bad_cmd_in), .faults_in(faults_in),
		.filament_on_in(filament_on_in), .overpressure_in(overpressure_in),
		.emission_fail_in(emission_fail_in), .retest_done_in(retest_done_in),
		.retest_in(retest_in),
		.reply_out(reply_out), .summary_out(summary_out), .selftest_req_out(selftest_req_out),
		.retest_req_out(retest_req_out), .filament_off_out(filament_off_out),
		.error_led_out(error_led_out), .burnt_led_out(burnt_led_out), .leak_led_out(leak_led_out)
	);
	esr_host_model esr_host_model_inst (
		.ref_clk_in(ref_clk_in), .reply_in(reply_out), .query_out(query_in)
	);
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		cmp_count++;
		if (s !== e) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic conclude;
		if (miscompares == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic reply_is(input esr_query_t c, input bit send, input logic [7:0] e);
		logic [7:0] d;
		bit         ok;
		if (send) esr_host_model_inst.ask(c, d, ok);
		else esr_host_model_inst.wait_reply(d, ok);
		chk("reply valid", 8'h01, 8'(ok));
		if (!ok) conclude();
		chk("reply data", e, d);
	endtask
	// Retest results come back after 1 to 3 clocks, so prompt and slow answers both occur
	always begin
		tick(1);
		if (retest_req_out != 3'h0) begin
			tick(int'(retest_req_out));
			retest_done_in = 1'b1;
			tick(1);
			retest_done_in = 1'b0;
		end
	end
	task automatic t_reset;
		chk("summary", 8'h00, summary_out);
		tick(1);
		chk("selftest", 8'h01, 8'(selftest_req_out));
		tick(1);
		chk("selftest", 8'h00, 8'(selftest_req_out));
	endtask
	task automatic t_retest;
		retest_in.electrometer = 8'h24;
		reply_is(ESR_Q_ELECTROMETER, 1'b1, 8'h24);
		tick(2);
		chk("summary", 8'h20, summary_out);
		retest_in = '0;
		reply_is(ESR_Q_ELECTROMETER, 1'b1, 8'h00);
		tick(2);
		chk("summary", 8'h00, summary_out);
	endtask
	task automatic t_emission;
		emission_fail_in = 1'b1;
		tick(2);
		chk("burnt led", 8'h01, 8'(burnt_led_out));
		chk("leak led", 8'h01, 8'(leak_led_out));
		chk("error led", 8'h01, 8'(error_led_out));
		emission_fail_in = 1'b0;
		tick(2);
		chk("burnt led", 8'h00, 8'(burnt_led_out));
	endtask
	task automatic t_checks;
		int         b[6] = '{6, 5, 4, 3, 1, 0};
		logic [7:0] v;
		for (int i = 0; i < 6; i++) begin
			v = (8'h80 >> i) | 8'h01;
			faults_in = 48'(v) << (8 * (5 - i));
			tick(1);
			faults_in = '0;
			tick(2);
			chk("summary", 8'h01 << b[i], summary_out);
			if (i < 5) chk("error led", 8'h01, 8'(error_led_out));
			reply_is(esr_query_t'(3'(i + 1)), 1'b1, (i < 3) ? 8'h00 : v);
			tick(2);
			chk("summary", 8'h00, summary_out);
		end
	endtask
	task automatic t_flash;
		int   rises;
		logic prev;
		rises = 0;
		tick(40);
		prev = error_led_out;
		bad_cmd_in = 1'b1;
		tick(1);
		bad_cmd_in = 1'b0;
		for (int i = 0; i < 40; i++) begin
			tick(1);
			if (error_led_out === 1'b1 && prev === 1'b0) rises++;
			prev = error_led_out;
		end
		chk("flash count", 8'h02, 8'(rises));
		reply_is(ESR_Q_COMMS, 1'b1, 8'h01);
	endtask
	task automatic t_filament;
		filament_on_in = 1'b1;
		tick(2);
		overpressure_in = 1'b1;
		tick(3);
		chk("filament off", 8'h01, 8'(filament_off_out));
		chk("burnt led", 8'h01, 8'(burnt_led_out));
		chk("leak led", 8'h01, 8'(leak_led_out));
		chk("summary", 8'h02, summary_out);
		overpressure_in = 1'b0;
		filament_on_in = 1'b0;
		tick(2);
		reply_is(ESR_Q_FILAMENT, 1'b1, 8'h40);
	endtask
	task automatic t_cmd_done;
		faults_in.multiplier = 8'h04;
		tick(1);
		faults_in = '0;
		cmd_done_in = 1'b1;
		tick(1);
		cmd_done_in = 1'b0;
		reply_is(ESR_Q_SUMMARY, 1'b0, 8'h08);
		reply_is(ESR_Q_SUMMARY, 1'b1, 8'h08);
		reply_is(ESR_Q_MULTIPLIER, 1'b1, 8'h04);
	endtask
	initial begin
		tick(6);
		reset_n_in = 1'b1;
		t_reset();
		t_checks();
		t_retest();
		t_flash();
		t_filament();
		t_emission();
		t_cmd_done();
		conclude();
	end
endmodule
